// ===== design/acl_defines.vh
// Register map, field positions, reset values and attenuation constants for the clip block.
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ACL_ADDR_RISE_EN 4'h2
`define ACL_ADDR_FALL_EN 4'h3
`define ACL_ADDR_IRQ_STAT 4'h4
`define ACL_ADDR_CTRL_B 4'h8
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACL_BIT_CLIP_IRQ 15
`define ACL_BIT_CLIP_FLAG 13
`define ACL_BIT_CLIP_CLR 12
`define ACL_ATTEN_MSB 4
`define ACL_ATTEN_W 5
// ----------------------------------------------------------------
// Reset values and attenuation figures
// ----------------------------------------------------------------
`define ACL_RST_ATTEN 5'h00
`define ACL_RST_DATA 16'h0000
`define ACL_ATTEN_STEP_DB 3
`define ACL_ATTEN_MAX_DB 69
`define ACL_ATTEN_MAX_IDX 5'h17
`define ACL_ANALOG_STEPS 8
`define ACL_DIGITAL_STEP_DB 24
`endif

// ===== design/acl_clip_irq_atten.v
// Clip status, clip edge interrupts and output attenuation split for the audio codec.
`timescale 1ns/1ps
// Notes on behaviour
// (R01) Clip flag sets whenever the synchronised clip-detect input is high.
// (R02) Clip flag clears only on a written zero-to-one transition of the clear bit.
// (R03) Rising clip edge raises the interrupt when the rise enable is set.
// (R04) Pending clip interrupt reads as bit 15 of the status register at 0x4.
// (R05) Falling clip edge raises the interrupt when the fall enable is set.
// (R06) Attenuation runs in 3 dB steps down to 69 dB.
// (R07) Steps 0 to 7 are analog only; the digital path stays unattenuated.
// (R08) Digital path offers 24 dB and 48 dB settings combined with analog steps.
// (R09) Clip flag stays set after the clip ends until the clear transition.
// (R10) Step index 0..23: analog part is index mod 8, digital 24 dB per 8.
module acl_clip_irq_atten (
  // Clock and reset
  input wire REF_CLK_I,
  input wire RST_I,
  // Clip detector, asynchronous to the clock
  input wire CLIP_DET_I,
  // Register port
  input wire REG_WE_I,
  input wire [3:0] REG_ADDR_I,
  input wire [15:0] REG_WDATA_I,
  output reg [15:0] REG_RDATA_O,
  // Interrupt output pin
  output wire IRQ_O,
  // Attenuation controls
  output reg [2:0] ANALOG_ATTEN_O,
  output reg [1:0] DIGITAL_ATTEN_O
);
`include "acl_defines.vh"

  // ----------------------------------------------------------------
  // Clip detect synchroniser and edge detection
  // ----------------------------------------------------------------
  reg clip_meta_q;
  reg clip_sync_q;
  reg clip_prev_q;
  wire clip_rise;
  wire clip_fall;

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      clip_meta_q <= 1'b0;
      clip_sync_q <= 1'b0;
      clip_prev_q <= 1'b0;
    end else begin
      clip_meta_q <= CLIP_DET_I;
      clip_sync_q <= clip_meta_q;
      clip_prev_q <= clip_sync_q;
    end
  end

  assign clip_rise = clip_sync_q & ~clip_prev_q;
  assign clip_fall = ~clip_sync_q & clip_prev_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  reg clip_rise_irq_enable_q;
  reg clip_fall_irq_enable_q;
  reg clip_flag_clear_q;
  reg [4:0] atten_q;
  reg [4:0] atten_d;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire wr_rise_en;
  wire wr_fall_en;
  wire wr_ctrl_b;
  wire wr_stat;
  wire clear_edge;

  assign wr_rise_en = REG_WE_I && (REG_ADDR_I == `ACL_ADDR_RISE_EN);
  assign wr_fall_en = REG_WE_I && (REG_ADDR_I == `ACL_ADDR_FALL_EN);
  assign wr_ctrl_b = REG_WE_I && (REG_ADDR_I == `ACL_ADDR_CTRL_B);
  assign wr_stat = REG_WE_I && (REG_ADDR_I == `ACL_ADDR_IRQ_STAT);
  assign clear_edge = wr_ctrl_b && REG_WDATA_I[`ACL_BIT_CLIP_CLR] && !clip_flag_clear_q; // R02

  always @* begin
    atten_d = REG_WDATA_I[`ACL_ATTEN_MSB:0];
    if (atten_d > `ACL_ATTEN_MAX_IDX) begin
      atten_d = `ACL_ATTEN_MAX_IDX; // R06
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      clip_rise_irq_enable_q <= 1'b0;
      clip_fall_irq_enable_q <= 1'b0;
      clip_flag_clear_q <= 1'b0;
      atten_q <= `ACL_RST_ATTEN;
    end else begin
      if (wr_rise_en) begin
        clip_rise_irq_enable_q <= REG_WDATA_I[`ACL_BIT_CLIP_IRQ];
      end
      if (wr_fall_en) begin
        clip_fall_irq_enable_q <= REG_WDATA_I[`ACL_BIT_CLIP_IRQ];
      end
      if (wr_ctrl_b) begin
        clip_flag_clear_q <= REG_WDATA_I[`ACL_BIT_CLIP_CLR];
        atten_q <= atten_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clip status flag
  // ----------------------------------------------------------------
  reg clip_flag_q;
  reg clip_flag_d;

  // Set wins over the clear transition while the clip input stays high.
  always @* begin
    clip_flag_d = clip_flag_q; // R09
    if (clip_sync_q) begin
      clip_flag_d = 1'b1; // R01
    end else if (clear_edge) begin
      clip_flag_d = 1'b0; // R02
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      clip_flag_q <= 1'b0;
    end else begin
      clip_flag_q <= clip_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Clip interrupt
  // ----------------------------------------------------------------
  reg clip_irq_pending_q;
  reg clip_irq_pending_d;
  wire irq_event;
  wire irq_clear;

  assign irq_event = (clip_rise && clip_rise_irq_enable_q) || // R03
                     (clip_fall && clip_fall_irq_enable_q); // R05
  assign irq_clear = wr_stat && REG_WDATA_I[`ACL_BIT_CLIP_IRQ];

  // An enabled edge in the same cycle as the status clear keeps the interrupt pending.
  always @* begin
    clip_irq_pending_d = clip_irq_pending_q;
    if (irq_event) begin
      clip_irq_pending_d = 1'b1;
    end else if (irq_clear) begin
      clip_irq_pending_d = 1'b0;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      clip_irq_pending_q <= 1'b0;
    end else begin
      clip_irq_pending_q <= clip_irq_pending_d;
    end
  end

  assign IRQ_O = clip_irq_pending_q; // R03 R05

  // ----------------------------------------------------------------
  // Attenuation split
  // ----------------------------------------------------------------
  reg [2:0] analog_atten_d;
  reg [1:0] digital_atten_d;

  // Indices 0 to 7 leave the digital path at 0 dB; each further 8 adds 24 dB there.
  always @* begin
    analog_atten_d = atten_q[2:0]; // R07 R10
    digital_atten_d = atten_q[4:3]; // R08 R10
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ANALOG_ATTEN_O <= 3'h0;
      DIGITAL_ATTEN_O <= 2'h0;
    end else begin
      ANALOG_ATTEN_O <= analog_atten_d;
      DIGITAL_ATTEN_O <= digital_atten_d;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  reg [15:0] rdata_d;

  always @* begin
    rdata_d = `ACL_RST_DATA;
    case (REG_ADDR_I)
      `ACL_ADDR_RISE_EN: begin
        rdata_d[`ACL_BIT_CLIP_IRQ] = clip_rise_irq_enable_q;
      end
      `ACL_ADDR_FALL_EN: begin
        rdata_d[`ACL_BIT_CLIP_IRQ] = clip_fall_irq_enable_q;
      end
      `ACL_ADDR_IRQ_STAT: begin
        rdata_d[`ACL_BIT_CLIP_IRQ] = clip_irq_pending_q; // R04
      end
      `ACL_ADDR_CTRL_B: begin
        rdata_d[`ACL_BIT_CLIP_FLAG] = clip_flag_q;
        rdata_d[`ACL_BIT_CLIP_CLR] = clip_flag_clear_q;
        rdata_d[`ACL_ATTEN_MSB:0] = atten_q;
      end
      default: begin
        rdata_d = `ACL_RST_DATA;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= `ACL_RST_DATA;
    end else begin
      REG_RDATA_O <= rdata_d;
    end
  end

endmodule

// ===== tb/acl_clip_src.sv
// Clip detector model clocked by its own slow clock.
`timescale 1ns/1ps
module acl_clip_src(input wire logic want_i, output logic clip_o);
  logic lclk = 1'b0;
  logic clip_q = 1'b0;
  always #80 lclk = ~lclk;
  always @(posedge lclk) clip_q <= want_i;
  assign clip_o = clip_q;
endmodule

// ===== tb/acl_clip_irq_atten_assertions.sv
// Port checks for the clip block.
`timescale 1ns/1ps
module acl_chk(input logic REF_CLK_I, RST_I, CLIP_DET_I, REG_WE_I, IRQ_O,
  input logic [3:0] REG_ADDR_I, input logic [15:0] REG_WDATA_I, REG_RDATA_O,
  input logic [2:0] ANALOG_ATTEN_O, input logic [1:0] DIGITAL_ATTEN_O);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire w8 = REG_WE_I && REG_ADDR_I == 4'h8;
  wire big = REG_WDATA_I[4:3] == 2'h3;
  a_atten_an: assert property (w8 && !big
    |-> ##2 ANALOG_ATTEN_O == $past(REG_WDATA_I[2:0], 2)) else $error("analog");
  a_atten_dg: assert property (w8 && !big
    |-> ##2 DIGITAL_ATTEN_O == $past(REG_WDATA_I[4:3], 2)) else $error("digital");
  a_atten_clamp: assert property (w8 && big
    |-> ##2 {DIGITAL_ATTEN_O, ANALOG_ATTEN_O} == 5'h17) else $error("clamp");
  a_atten_hold: assert property (!REG_WE_I ##1 !REG_WE_I
    |=> $stable({DIGITAL_ATTEN_O, ANALOG_ATTEN_O})) else $error("atten");
  a_irq_hold: assert property (IRQ_O && !(REG_WE_I && REG_ADDR_I == 4'h4
    && REG_WDATA_I[15]) |=> IRQ_O) else $error("irq drop");
  a_irq_read: assert property (REG_ADDR_I == 4'h4
    |=> REG_RDATA_O[15] == $past(IRQ_O)) else $error("pending");
  a_irq_quiet: assert property ($stable(CLIP_DET_I)[*6] ##1 !IRQ_O
    |=> !IRQ_O) else $error("irq");
  a_flag_stay: assert property ($past(REG_ADDR_I) == 4'h8 && REG_ADDR_I == 4'h8
    && REG_RDATA_O[13] && !$past(REG_WE_I) |=> REG_RDATA_O[13]) else $error("flag");
  c_rise: cover property ($rose(IRQ_O));
  c_clr: cover property (w8 && REG_WDATA_I[12]);
  c_big: cover property (w8 && big);
endmodule
bind acl_clip_irq_atten acl_chk u_acl_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .CLIP_DET_I(CLIP_DET_I), .REG_WE_I(REG_WE_I), .IRQ_O(IRQ_O), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .ANALOG_ATTEN_O(ANALOG_ATTEN_O), .DIGITAL_ATTEN_O(DIGITAL_ATTEN_O));

// ===== tb/tb_acl_clip_irq_atten.sv
// Self-checking bench for the clip block.
`timescale 1ns/1ps
module tb_acl_clip_irq_atten;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, want = 1'b0, irq;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000, rd;
  logic [2:0] an;
  logic [1:0] dg;
  logic [4:0] idx [5] = '{5'h00, 5'h07, 5'h08, 5'h17, 5'h1f};
  logic [4:0] ea;
  wire clip;
  int mismatches = 0, num_checks = 0;
  acl_clip_src u_acl_clip_src (.want_i(want), .clip_o(clip));
  acl_clip_irq_atten u_acl_clip_irq_atten (.REF_CLK_I(clk), .RST_I(rst), .CLIP_DET_I(clip),
    .REG_WE_I(we), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rd), .IRQ_O(irq),
    .ANALOG_ATTEN_O(an), .DIGITAL_ATTEN_O(dg));
  initial forever #4 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] m, e, input string n);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk(n, e, rd & m);
  endtask
  task automatic wi(input logic e);
    for (int i = 0; i < 60 && irq !== e; i++) @(negedge clk);
    chk("irq", {15'h0000, e}, {15'h0000, irq});
    if (irq !== e) wrap_up();
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rc(4'h4, 16'hffff, 16'h0000, "stat");
    rc(4'h8, 16'hffff, 16'h0000, "ctrl");
    $display("end reset");
    foreach (idx[i]) begin
      ea = (idx[i] > 5'h17) ? 5'h17 : idx[i];
      wr(4'h8, {11'h000, idx[i]});
      @(negedge clk);
      chk("att", {11'h000, ea}, {11'h000, dg, an});
      rc(4'h8, 16'h001f, {11'h000, ea}, "att_rd");
    end
    $display("end atten");
    wr(4'h2, 16'h8000);
    rc(4'h2, 16'hffff, 16'h8000, "rise_en");
    want = 1'b1;
    wi(1'b1);
    rc(4'h4, 16'h8000, 16'h8000, "pend");
    want = 1'b0;
    repeat (60) @(negedge clk);
    rc(4'h8, 16'h2000, 16'h2000, "held");
    wr(4'h4, 16'h8000);
    wi(1'b0);
    wr(4'h8, 16'h1000);
    rc(4'h8, 16'h2000, 16'h0000, "clr");
    $display("end rise");
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h8000);
    rc(4'h3, 16'hffff, 16'h8000, "fall_en");
    want = 1'b1;
    repeat (60) @(negedge clk);
    chk("norise", 16'h0000, {15'h0000, irq});
    wr(4'h8, 16'h0000);
    wr(4'h8, 16'h1000);
    rc(4'h8, 16'h2000, 16'h2000, "setwins");
    want = 1'b0;
    wi(1'b1);
    rc(4'h4, 16'h8000, 16'h8000, "pendf");
    wr(4'h8, 16'h1000);
    rc(4'h8, 16'h2000, 16'h2000, "noclr");
    wr(4'h8, 16'h0000);
    wr(4'h8, 16'h1000);
    rc(4'h8, 16'h2000, 16'h0000, "clr2");
    $display("end fall");
    wrap_up();
  end
endmodule
